// ==== hw/dfd_pkg.sv ====
// Package of constants for the driver fault diagnosis block
package dfd_pkg;
  // ----------------------------------------------------------------
  // Fault codes, first reported bit in bit 1
  // ----------------------------------------------------------------
  localparam logic [1:0] DFD_CODE_OK = 2'h3;
  localparam logic [1:0] DFD_CODE_OPEN = 2'h1;
  localparam logic [1:0] DFD_CODE_BAT = 2'h2;
  localparam logic [1:0] DFD_CODE_GND = 2'h0;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] DFD_ADDR_CMD = 8'h00;
  localparam logic [7:0] DFD_ADDR_CFG1 = 8'h04;
  localparam logic [7:0] DFD_ADDR_CFG2 = 8'h08;
  localparam logic [7:0] DFD_ADDR_DIAG = 8'h0c;
  localparam logic [7:0] DFD_ADDR_STAT = 8'h10;
  // ----------------------------------------------------------------
  // Configuration bit positions
  // ----------------------------------------------------------------
  localparam int DFD_CFG1_OUTPUT_DISABLE_BIT = 0;
  localparam int DFD_CFG1_PULL_DIS = 1;
  localparam int DFD_CFG1_GND_METHOD = 2;
  localparam int DFD_CFG1_BAT_LATCH = 3;
  localparam int DFD_CFG2_IGN_LS_OFF = 0;
  localparam logic [31:0] DFD_CFG1_RST = 32'h0000_0008;
  localparam logic [31:0] DFD_CFG2_RST = 32'h0000_0000;
  // ----------------------------------------------------------------
  // Timing in ns, clock period in ns
  // ----------------------------------------------------------------
  localparam int DFD_CLK_NS = 50;
  localparam int DFD_OVC_FILT_NS = 5000;
  localparam int DFD_OFF_FILT_NS = 65000;
  localparam int DFD_MASK_NS = 500000;
  localparam int DFD_IGN_FILT_NS = 100000;
  localparam int DFD_OVC_FILT_CYC = DFD_OVC_FILT_NS / DFD_CLK_NS;
  localparam int DFD_OFF_FILT_CYC = DFD_OFF_FILT_NS / DFD_CLK_NS;
  localparam int DFD_MASK_CYC = (DFD_MASK_NS + DFD_CLK_NS - 1) / DFD_CLK_NS;
  localparam int DFD_IGN_FILT_CYC = DFD_IGN_FILT_NS / DFD_CLK_NS;
  localparam int DFD_CNT_W = 16;
endpackage : dfd_pkg

// ==== hw/dfd_top.sv ====
// Fault diagnosis and protection for low-side and ignition channels
//
// What this block does
// (R1) Each channel reports 2-bit code: 11 ok, 01 open, 10 battery, 00 ground.
// (R2) Low-side fault codes hold until each diagnosis read returns them to ok.
// (R3) While off, first fault is kept; only an on-state fault replaces it.
// (R4) Continuous overcurrent past filter time switches low-side off, latches code.
// (R5) After overcurrent, drive returns on command re-edge or diagnosis read.
// (R6) Off-state voltage below low is ground, between is open, above is ok.
// (R7) Off-state results are ignored for mask delay after each switch-off.
// (R8) Off-state faults need the off filter time, then latch until read.
// (R9) Pull disable bit blocks open and ground detection on low-current group.
// (R10) Ignition outputs go high impedance on reset or output disable bit.
// (R11) Configuration word two bit zero forces ignition low-side stage off.
// (R12) Select bit picks current or voltage method for ignition ground short.
// (R13) Current method: overcurrent past filter latches ground code, tri-states.
// (R14) Voltage method: voltage below low past filter latches ground, tri-states.
// (R15) Ground tri-state ends on diagnosis read or command off-on cycle.
// (R16) Low current past filter latches open code; output stays driven.
// (R17) Voltage above battery threshold past filter sets battery code, tri-states.
// (R18) Battery short outranks open load on an ignition channel.
// (R19) Mode bit selects latched or non-latched battery short handling.
// (R20) Latched: code clears on read; drive returns on read or off-on.
// (R21) Non-latched: voltage back below threshold past filter clears fault.
// (R22) Host commands outputs and reads diagnosis over the control channel.
// (R23) Filter timers restart when their condition drops before expiry.
`timescale 1ns/1ps
`default_nettype none
module dfd_top
  import dfd_pkg::*;
#(
  parameter int NLS = 4,
  parameter int NIGN = 4,
  parameter logic [NLS-1:0] LC_GROUP = 4'hc,
  parameter int MASK_CYC = DFD_MASK_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NLS-1:0] ls_ovc_in,
  input wire logic [NLS-1:0] ls_below_low_in,
  input wire logic [NLS-1:0] ls_above_high_in,
  input wire logic [NIGN-1:0] ign_ovc_in,
  input wire logic [NIGN-1:0] ign_below_low_in,
  input wire logic [NIGN-1:0] ign_low_cur_in,
  input wire logic [NIGN-1:0] ign_above_bat_in,
  output logic [NLS-1:0] ls_drive,
  output logic [NLS-1:0] ls_pull_en,
  output logic [NIGN-1:0] ign_hs_on,
  output logic [NIGN-1:0] ign_ls_on,
  output logic [NIGN-1:0] ign_oe_n
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int NIN = 3 * NLS + 4 * NIGN;
  logic [NIN-1:0] sync1_r;
  logic [NIN-1:0] sync2_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {ls_ovc_in, ls_below_low_in, ls_above_high_in, ign_ovc_in,
                  ign_below_low_in, ign_low_cur_in, ign_above_bat_in};
      sync2_r <= sync1_r;
    end
  end
  logic [NLS-1:0] ls_ovc, ls_low, ls_high;
  logic [NIGN-1:0] ig_ovc, ig_low, ig_lcur, ig_bat;
  assign {ls_ovc, ls_low, ls_high, ig_ovc, ig_low, ig_lcur, ig_bat} = sync2_r;

  // ----------------------------------------------------------------
  // Register file over APB
  // ----------------------------------------------------------------
  logic [31:0] cmd_r, cfg1_r, cfg2_r;
  logic diag_rd;
  logic apb_acc, apb_wr, addr_ok;
  assign apb_acc = psel && penable;
  assign apb_wr = apb_acc && pwrite;
  assign addr_ok = (paddr == DFD_ADDR_CMD) || (paddr == DFD_ADDR_CFG1) ||
                   (paddr == DFD_ADDR_CFG2) || (paddr == DFD_ADDR_DIAG) ||
                   (paddr == DFD_ADDR_STAT);
  // (R22) Diagnosis read event
  assign diag_rd = apb_acc && !pwrite && (paddr == DFD_ADDR_DIAG);
  // Zero-wait slave: ready held high from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b1;
    end else begin
      pready <= 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_r <= '0;
      cfg1_r <= DFD_CFG1_RST;
      cfg2_r <= DFD_CFG2_RST;
    end else if (apb_wr) begin
      if (paddr == DFD_ADDR_CMD) cmd_r <= pwdata;
      if (paddr == DFD_ADDR_CFG1) cfg1_r <= pwdata;
      if (paddr == DFD_ADDR_CFG2) cfg2_r <= pwdata;
    end
  end
  logic output_disable_bit, pull_dis, gnd_by_volt, bat_latch, ign_ls_off;
  assign output_disable_bit = cfg1_r[DFD_CFG1_OUTPUT_DISABLE_BIT];
  assign pull_dis = cfg1_r[DFD_CFG1_PULL_DIS];
  assign gnd_by_volt = cfg1_r[DFD_CFG1_GND_METHOD];
  assign bat_latch = cfg1_r[DFD_CFG1_BAT_LATCH];
  assign ign_ls_off = cfg2_r[DFD_CFG2_IGN_LS_OFF];
  logic [NLS-1:0] ls_cmd;
  logic [NIGN-1:0] ig_cmd;
  assign ls_cmd = cmd_r[NLS-1:0];
  assign ig_cmd = cmd_r[16+NIGN-1:16];

  // Filter counter step: restart when condition drops, saturate at all ones
  function automatic logic [DFD_CNT_W-1:0] flt_step(
    input logic cond, input logic [DFD_CNT_W-1:0] cnt);
    // (R23) Restart on drop
    if (!cond) flt_step = '0;
    else if (cnt != '1) flt_step = cnt + 1'b1;
    else flt_step = cnt;
  endfunction : flt_step

  // ----------------------------------------------------------------
  // Low-side channels
  // ----------------------------------------------------------------
  localparam logic [DFD_CNT_W-1:0] OVC_LIM = DFD_CNT_W'(DFD_OVC_FILT_CYC);
  localparam logic [DFD_CNT_W-1:0] OFF_LIM = DFD_CNT_W'(DFD_OFF_FILT_CYC);
  localparam logic [DFD_CNT_W-1:0] MSK_LIM = DFD_CNT_W'(MASK_CYC);
  logic [1:0] ls_code_r [NLS];
  logic [NLS-1:0] ls_trip_r, ls_cmd_q_r, ls_drv_q_r, ls_off_hold_r;
  logic [DFD_CNT_W-1:0] ls_ovc_cnt_r [NLS];
  logic [DFD_CNT_W-1:0] ls_gnd_cnt_r [NLS];
  logic [DFD_CNT_W-1:0] ls_opn_cnt_r [NLS];
  logic [DFD_CNT_W-1:0] ls_msk_cnt_r [NLS];
  for (genvar i = 0; i < NLS; i++) begin : g_ls
    logic on_st, diag_ok, gnd_c, opn_c, ovc_hit, gnd_hit, opn_hit;
    assign on_st = ls_cmd[i] && !ls_trip_r[i];
    // (R7) Mask after switch-off; (R9) pull disable on low-current group
    assign diag_ok = !on_st && (ls_msk_cnt_r[i] >= MSK_LIM) &&
                     !(pull_dis && LC_GROUP[i]);
    // (R6) Voltage classification
    assign gnd_c = diag_ok && ls_low[i];
    assign opn_c = diag_ok && !ls_low[i] && !ls_high[i];
    // (R4) Overcurrent filter
    assign ovc_hit = on_st && ls_ovc[i] && (ls_ovc_cnt_r[i] >= OVC_LIM);
    // (R8) Off-state filter
    assign gnd_hit = gnd_c && (ls_gnd_cnt_r[i] >= OFF_LIM);
    assign opn_hit = opn_c && (ls_opn_cnt_r[i] >= OFF_LIM);
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ls_ovc_cnt_r[i] <= '0;
        ls_gnd_cnt_r[i] <= '0;
        ls_opn_cnt_r[i] <= '0;
        ls_msk_cnt_r[i] <= '0;
      end else begin
        ls_ovc_cnt_r[i] <= flt_step(on_st && ls_ovc[i], ls_ovc_cnt_r[i]);
        ls_gnd_cnt_r[i] <= flt_step(gnd_c, ls_gnd_cnt_r[i]);
        ls_opn_cnt_r[i] <= flt_step(opn_c, ls_opn_cnt_r[i]);
        ls_msk_cnt_r[i] <= on_st ? '0 : flt_step(1'b1, ls_msk_cnt_r[i]);
      end
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ls_code_r[i] <= DFD_CODE_OK;
        ls_trip_r[i] <= 1'b0;
        ls_cmd_q_r[i] <= 1'b0;
        ls_off_hold_r[i] <= 1'b0;
      end else begin
        ls_cmd_q_r[i] <= ls_cmd[i];
        // (R4) Overcurrent shutdown, set wins over read
        if (ovc_hit) begin
          ls_code_r[i] <= DFD_CODE_BAT;
          ls_trip_r[i] <= 1'b1;
          ls_off_hold_r[i] <= 1'b0;
        end else if ((gnd_hit || opn_hit) && !ls_off_hold_r[i]) begin
          // (R3) First off-state fault kept
          ls_code_r[i] <= gnd_hit ? DFD_CODE_GND : DFD_CODE_OPEN;
          ls_off_hold_r[i] <= 1'b1;
        end else if (diag_rd) begin
          // (R2) Read returns code to ok
          ls_code_r[i] <= DFD_CODE_OK;
          ls_off_hold_r[i] <= 1'b0;
        end
        // (R5) Re-enable on read or command low then high
        if (!ovc_hit && ls_trip_r[i] &&
            (diag_rd || (ls_cmd[i] && !ls_cmd_q_r[i])))
          ls_trip_r[i] <= 1'b0;
      end
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ls_drive[i] <= 1'b0;
        ls_pull_en[i] <= 1'b0;
      end else begin
        ls_drive[i] <= on_st && !ovc_hit;
        ls_pull_en[i] <= !on_st && !(pull_dis && LC_GROUP[i]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Ignition channels
  // ----------------------------------------------------------------
  localparam logic [DFD_CNT_W-1:0] IGN_LIM = DFD_CNT_W'(DFD_IGN_FILT_CYC);
  logic [1:0] ig_code_r [NIGN];
  logic [NIGN-1:0] ig_gnd_tri_r, ig_bat_tri_r, ig_cmd_q_r;
  logic [DFD_CNT_W-1:0] ig_gnd_cnt_r [NIGN];
  logic [DFD_CNT_W-1:0] ig_opn_cnt_r [NIGN];
  logic [DFD_CNT_W-1:0] ig_bat_cnt_r [NIGN];
  logic [DFD_CNT_W-1:0] ig_clr_cnt_r [NIGN];
  for (genvar i = 0; i < NIGN; i++) begin : g_ig
    logic tri_st, on_st, gnd_c, gnd_hit, opn_hit, bat_hit, clr_hit, reon;
    assign tri_st = ig_gnd_tri_r[i] || ig_bat_tri_r[i];
    assign on_st = ig_cmd[i] && !tri_st;
    // (R12) Method select for ground short
    assign gnd_c = on_st && (gnd_by_volt ? ig_low[i] : ig_ovc[i]);
    // (R13) (R14) Filtered ground short
    assign gnd_hit = gnd_c && (ig_gnd_cnt_r[i] >= IGN_LIM);
    // (R16) Filtered open load
    assign opn_hit = on_st && ig_lcur[i] && (ig_opn_cnt_r[i] >= IGN_LIM);
    // (R17) Battery short in on or off state
    assign bat_hit = ig_bat[i] && (ig_bat_cnt_r[i] >= IGN_LIM);
    // (R21) Voltage back below threshold past filter
    assign clr_hit = !bat_latch && ig_bat_tri_r[i] && !ig_bat[i] &&
                     (ig_clr_cnt_r[i] >= IGN_LIM);
    assign reon = diag_rd || (ig_cmd[i] && !ig_cmd_q_r[i]);
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ig_gnd_cnt_r[i] <= '0;
        ig_opn_cnt_r[i] <= '0;
        ig_bat_cnt_r[i] <= '0;
        ig_clr_cnt_r[i] <= '0;
      end else begin
        ig_gnd_cnt_r[i] <= flt_step(gnd_c, ig_gnd_cnt_r[i]);
        ig_opn_cnt_r[i] <= flt_step(on_st && ig_lcur[i], ig_opn_cnt_r[i]);
        ig_bat_cnt_r[i] <= flt_step(ig_bat[i], ig_bat_cnt_r[i]);
        ig_clr_cnt_r[i] <= flt_step(ig_bat_tri_r[i] && !ig_bat[i],
                                    ig_clr_cnt_r[i]);
      end
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ig_code_r[i] <= DFD_CODE_OK;
        ig_gnd_tri_r[i] <= 1'b0;
        ig_bat_tri_r[i] <= 1'b0;
        ig_cmd_q_r[i] <= 1'b0;
      end else begin
        ig_cmd_q_r[i] <= ig_cmd[i];
        // (R18) Battery short outranks the rest
        if (bat_hit) begin
          ig_code_r[i] <= DFD_CODE_BAT;
          ig_bat_tri_r[i] <= 1'b1;
        end else if (gnd_hit) begin
          ig_code_r[i] <= DFD_CODE_GND;
          ig_gnd_tri_r[i] <= 1'b1;
        end else if (opn_hit && ig_code_r[i] != DFD_CODE_BAT) begin
          ig_code_r[i] <= DFD_CODE_OPEN;
        end else if (clr_hit) begin
          // (R19) (R21) Non-latched clear
          ig_code_r[i] <= DFD_CODE_OK;
          ig_bat_tri_r[i] <= 1'b0;
        end else begin
          // (R20) Latched: read clears code
          if (diag_rd && (bat_latch || !ig_bat_tri_r[i]))
            ig_code_r[i] <= DFD_CODE_OK;
          // (R15) (R20) Drive returns on read or off-on
          if (reon) begin
            ig_gnd_tri_r[i] <= 1'b0;
            if (bat_latch) ig_bat_tri_r[i] <= 1'b0;
          end
        end
      end
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        // (R10) High impedance during reset
        ign_hs_on[i] <= 1'b0;
        ign_ls_on[i] <= 1'b0;
        ign_oe_n[i] <= 1'b1;
      end else begin
        // (R10) Output disable; (R16) open load keeps drive
        ign_oe_n[i] <= output_disable_bit || tri_st || gnd_hit || bat_hit;
        ign_hs_on[i] <= on_st && !gnd_hit && !bat_hit && !output_disable_bit;
        // (R11) Low-side stage forced off
        ign_ls_on[i] <= !ig_cmd[i] && !tri_st && !bat_hit && !output_disable_bit &&
                        !ign_ls_off;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [31:0] diag_word;
  always_comb begin
    diag_word = '0;
    // (R1) Two bits per channel, low-side then ignition
    for (int k = 0; k < NLS; k++) diag_word[2*k +: 2] = ls_code_r[k];
    for (int k = 0; k < NIGN; k++) diag_word[16+2*k +: 2] = ig_code_r[k];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= !addr_ok;
      case (paddr)
        DFD_ADDR_CMD: prdata <= cmd_r;
        DFD_ADDR_CFG1: prdata <= cfg1_r;
        DFD_ADDR_CFG2: prdata <= cfg2_r;
        DFD_ADDR_DIAG: prdata <= diag_word;
        DFD_ADDR_STAT: prdata <= {8'h00, 4'h0, 4'(ign_oe_n),
                                  12'h000, 4'(ls_trip_r)};
        default: prdata <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb_chk @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_tri_on_disable: assert property (output_disable_bit |=> &ign_oe_n) // (R10)
    else $error("ignition not tri-stated");
  a_ls_off_forced: assert property (ign_ls_off |=> ign_ls_on == '0) // (R11)
    else $error("ls stage on");
  a_read_clears_ls: assert property (diag_rd && !(|ls_ovc) && // (R2)
    !(|ls_low) && &ls_high |=> ls_code_r[0] == DFD_CODE_OK)
    else $error("read did not clear");
  a_trip_drive_off: assert property (ls_trip_r[0] |-> !ls_drive[0]) // (R4)
    else $error("drive while tripped");
  a_trip_code: assert property ( // (R4)
    $rose(ls_trip_r[0]) |-> ls_code_r[0] == DFD_CODE_BAT)
    else $error("trip without code");
  a_mask_pull: assert property ( // (R9)
    pull_dis && LC_GROUP[2] && ls_code_r[2][1] |=> ls_code_r[2][1])
    else $error("off-state fault while pull disabled");
  a_bat_tri: assert property ( // (R17)
    $rose(ig_bat_tri_r[0]) |-> ##1 ign_oe_n[0])
    else $error("bat no tri");
  a_gnd_tri: assert property ( // (R13)
    $rose(ig_gnd_tri_r[0]) |-> ig_code_r[0] == DFD_CODE_GND)
    else $error("gnd code wrong");
endmodule : dfd_top
`default_nettype wire

// ==== verif/dfd_load_model.sv ====
// Load and comparator model facing the driver outputs
`timescale 1ns/1ps
`default_nettype none
module dfd_load_model (
  input wire logic [3:0] ls_drive,
  input wire logic [3:0] ls_pull_en,
  input wire logic [3:0] ign_hs_on,
  input wire logic [3:0] ign_oe_n,
  input wire logic [11:0] ls_f,
  input wire logic [11:0] ign_f,
  output logic [3:0] ls_ovc,
  output logic [3:0] ls_low,
  output logic [3:0] ls_high,
  output logic [3:0] ign_ovc,
  output logic [3:0] ign_low,
  output logic [3:0] ign_lcur,
  output logic [3:0] ign_bat
);
  // Fault kinds: 0 ok, 1 overcurrent, 2 ground, 3 open, 4 battery, 5 both
  logic [2:0] f;
  logic [2:0] g;
  logic on;
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      f = ls_f[3*k+:3];
      g = ign_f[3*k+:3];
      on = ign_hs_on[k] & ~ign_oe_n[k];
      ls_ovc[k] = ls_drive[k] & (f == 3'h1);
      // An open pin floats low once the pull currents stop
      ls_low[k] = ls_drive[k] | (f == 3'h2) | ((f == 3'h3) & ~ls_pull_en[k]);
      ls_high[k] = ~ls_drive[k] & (f != 3'h2) & (f != 3'h3);
      ign_ovc[k] = on & (g == 3'h1);
      ign_low[k] = on ? (g == 3'h2) : (g < 3'h4);
      ign_lcur[k] = ~on | (g == 3'h3) | (g == 3'h5);
      ign_bat[k] = (g >= 3'h4);
    end
  end
endmodule : dfd_load_model
`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking bench for the driver fault diagnosis block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dfd_pkg::*;
  localparam int MASK = 20;
  localparam int IGN = DFD_IGN_FILT_CYC;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] ls_ovc, ls_low, ls_high, ign_ovc, ign_low, ign_lcur, ign_bat;
  logic [3:0] ls_drive, ls_pull_en, ign_hs_on, ign_ls_on, ign_oe_n;
  logic [11:0] ls_f = 12'h0;
  logic [11:0] ign_f = 12'h0;
  logic [31:0] q;
  logic e;
  int err_total = 0;
  int cmp_count = 0;

  always #25 pclk = ~pclk;

  dfd_top #(.MASK_CYC(MASK)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ls_ovc_in(ls_ovc), .ls_below_low_in(ls_low), .ls_above_high_in(ls_high),
    .ign_ovc_in(ign_ovc), .ign_below_low_in(ign_low),
    .ign_low_cur_in(ign_lcur), .ign_above_bat_in(ign_bat),
    .ls_drive(ls_drive), .ls_pull_en(ls_pull_en), .ign_hs_on(ign_hs_on),
    .ign_ls_on(ign_ls_on), .ign_oe_n(ign_oe_n));

  dfd_load_model u_load (.ls_drive(ls_drive), .ls_pull_en(ls_pull_en),
    .ign_hs_on(ign_hs_on), .ign_oe_n(ign_oe_n), .ls_f(ls_f), .ign_f(ign_f),
    .ls_ovc(ls_ovc), .ls_low(ls_low), .ls_high(ls_high), .ign_ovc(ign_ovc),
    .ign_low(ign_low), .ign_lcur(ign_lcur), .ign_bat(ign_bat));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] x);
    cmp_count++;
    if (s !== x) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, x, s);
    end
  endtask : chk

  task automatic cd(input string n, input int p, input logic [1:0] x);
    chk(n, {30'h0, q[p+:2]}, {30'h0, x});
  endtask : cd

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    @(posedge pclk);
  endtask : apb

  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    apb(1'b0, DFD_ADDR_CFG1, 32'h0);
    chk("cfg1 reset", q, DFD_CFG1_RST);
    apb(1'b0, DFD_ADDR_DIAG, 32'h0);
    chk("diag reset", q & 32'h00ff00ff, 32'h00ff00ff);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", {31'h0, e}, 32'h1);
    $display("test reset done");
  endtask : t_reset

  task automatic t_ls_ovc();
    apb(1'b1, DFD_ADDR_CMD, 32'h1);
    chk("ls on", {28'h0, ls_drive}, 32'h1);
    ls_f[2:0] <= 3'h1;
    cyc(DFD_OVC_FILT_CYC - 40);
    ls_f[2:0] <= 3'h0;
    cyc(5);
    ls_f[2:0] <= 3'h1;
    cyc(DFD_OVC_FILT_CYC - 10);
    chk("ovc early", {28'h0, ls_drive}, 32'h1);
    cyc(30);
    chk("ovc trip", {28'h0, ls_drive}, 32'h0);
    ls_f[2:0] <= 3'h0;
    cyc(5);
    apb(1'b0, DFD_ADDR_DIAG, 32'h0);
    cd("ls0 ovc", 0, DFD_CODE_BAT);
    chk("ls read on", {28'h0, ls_drive}, 32'h1);
    apb(1'b0, DFD_ADDR_DIAG, 32'h0);
    cd("ls0 clear", 0, DFD_CODE_OK);
    ls_f[2:0] <= 3'h1;
    cyc(DFD_OVC_FILT_CYC + 30);
    chk("ovc trip again", {28'h0, ls_drive}, 32'h0);
    ls_f[2:0] <= 3'h0;
    apb(1'b1, DFD_ADDR_CMD, 32'h0);
    apb(1'b1, DFD_ADDR_CMD, 32'h1);
    cyc(1);
    chk("ls re-edge", {28'h0, ls_drive}, 32'h1);
    $display("test low-side overcurrent done");
  endtask : t_ls_ovc

  task automatic t_ls_off();
    apb(1'b1, DFD_ADDR_CFG1, 32'ha);
    apb(1'b1, DFD_ADDR_CMD, 32'h6);
    ls_f[8:3] <= 6'h12;
    apb(1'b1, DFD_ADDR_CMD, 32'h0);
    cyc(MASK + DFD_OFF_FILT_CYC - 5);
    apb(1'b0, DFD_ADDR_DIAG, 32'h0);
    cd("gnd early", 2, DFD_CODE_OK);
    cyc(200);
    chk("pull en", {28'h0, ls_pull_en}, 32'h3);
    ls_f[8:3] <= 6'h0;
    cyc(5);
    apb(1'b0, DFD_ADDR_DIAG, 32'h0);
    cd("ls1 gnd", 2, DFD_CODE_GND);
    cd("ls2 no pull", 4, DFD_CODE_OK);
    ls_f[5:3] <= 3'h3;
    cyc(DFD_OFF_FILT_CYC + 100);
    ls_f[5:3] <= 3'h2;
    cyc(DFD_OFF_FILT_CYC + 100);
    ls_f[5:3] <= 3'h0;
    cyc(5);
    apb(1'b0, DFD_ADDR_DIAG, 32'h0);
    cd("ls1 first", 2, DFD_CODE_OPEN);
    $display("test low-side off-state done");
  endtask : t_ls_off

  task automatic t_ign_gnd();
    apb(1'b1, DFD_ADDR_CMD, 32'hf0000);
    chk("ign on", {24'h0, ign_hs_on, ign_oe_n}, 32'hf0);
    ign_f[5:0] <= 6'h11;
    cyc(IGN - 50);
    chk("ign early", {28'h0, ign_oe_n}, 32'h0);
    cyc(100);
    chk("ign ovc", {28'h0, ign_oe_n}, 32'h1);
    ign_f <= 12'h0;
    cyc(5);
    apb(1'b0, DFD_ADDR_DIAG, 32'h0);
    cd("ign0 gnd", 16, DFD_CODE_GND);
    cd("ign1 method", 18, DFD_CODE_OK);
    chk("ign read", {28'h0, ign_oe_n}, 32'h0);
    apb(1'b1, DFD_ADDR_CFG1, 32'he);
    ign_f[5:3] <= 3'h2;
    cyc(IGN + 50);
    chk("ign vlow", {28'h0, ign_oe_n}, 32'h2);
    ign_f <= 12'h0;
    apb(1'b1, DFD_ADDR_CMD, 32'h0);
    apb(1'b1, DFD_ADDR_CMD, 32'hf0000);
    cyc(1);
    chk("ign off-on", {28'h0, ign_oe_n}, 32'h0);
    apb(1'b0, DFD_ADDR_DIAG, 32'h0);
    cd("ign1 gnd", 18, DFD_CODE_GND);
    $display("test ignition ground done");
  endtask : t_ign_gnd

  task automatic t_ign_bat();
    ign_f[11:6] <= 6'h2b;
    cyc(IGN + 50);
    chk("open bat", {28'h0, ign_oe_n}, 32'h8);
    ign_f <= 12'h0;
    cyc(5);
    apb(1'b0, DFD_ADDR_DIAG, 32'h0);
    cd("ign2 open", 20, DFD_CODE_OPEN);
    cd("ign3 bat", 22, DFD_CODE_BAT);
    chk("latch read", {28'h0, ign_oe_n}, 32'h0);
    apb(1'b0, DFD_ADDR_DIAG, 32'h0);
    cd("ign3 clear", 22, DFD_CODE_OK);
    apb(1'b1, DFD_ADDR_CFG1, 32'h6);
    apb(1'b1, DFD_ADDR_CMD, 32'h0);
    ign_f[11:9] <= 3'h4;
    cyc(IGN + 50);
    chk("bat off", {28'h0, ign_oe_n}, 32'h8);
    ign_f <= 12'h0;
    cyc(IGN - 50);
    chk("bat hold", {28'h0, ign_oe_n}, 32'h8);
    cyc(100);
    chk("bat gone", {28'h0, ign_oe_n}, 32'h0);
    apb(1'b0, DFD_ADDR_DIAG, 32'h0);
    cd("ign3 ok", 22, DFD_CODE_OK);
    $display("test ignition battery done");
  endtask : t_ign_bat

  task automatic t_ign_cfg();
    apb(1'b1, DFD_ADDR_CFG1, 32'h7);
    chk("output_disable_bit", {28'h0, ign_oe_n}, 32'hf);
    apb(1'b1, DFD_ADDR_CFG1, 32'h6);
    chk("ls stage", {28'h0, ign_ls_on}, 32'hf);
    apb(1'b1, DFD_ADDR_CFG2, 32'h1);
    chk("ls forced", {28'h0, ign_ls_on}, 32'h0);
    $display("test ignition config done");
  endtask : t_ign_cfg

  initial begin
    cyc(3);
    chk("oe_n in reset", {28'h0, ign_oe_n}, 32'hf);
    presetn <= 1'b1;
    t_reset();
    t_ls_ovc();
    t_ls_off();
    t_ign_gnd();
    t_ign_bat();
    t_ign_cfg();
    summarize();
  end

  initial begin
    #2000000;
    err_total++;
    summarize();
  end
endmodule : tb
`default_nettype wire
